// ### design/lacr_regs.sv
// lacr_regs: legacy adapter compatibility register bank (mode, colour select, status).
// assumes host i/o strobes one cycle wide, synchronous to clk_i; raster inputs synchronous.
//
// Notes on behaviour
// RULE1 - compatibility registers respond only while extension select bit 6 is set
// RULE2 - 400-line register also needs extension bit 7; that register lives elsewhere
// RULE3 - wildcard ports decode to 3Bx when misc bit 0 clear, 3Dx when set
// RULE4 - mono bit 7 picks page B800 only when mono bit 1 and graphics bit 0 set
// RULE5 - mono bit 3 enables video, bit 5 enables blink, bit 0 high resolution
// RULE6 - mono bit 1 clear blocks setting graphics-config bits, forcing text
// RULE7 - graphics-config register is write-only, two bits, active only in compat mode
// RULE8 - graphics-config bit 1 clear maps out upper page at B800
// RULE9 - graphics-config bit 0 clear forces text; set allows graphics, subject to override
// RULE10 - colour mode bit 5 enables blinking
// RULE11 - colour mode bit 4 selects 640 by 200 two-colour graphics
// RULE12 - colour mode bit 3 clear deactivates the video signal
// RULE13 - colour mode bit 1 selects 320x200 graphics, bit 0 selects 80x25 text
// RULE14 - colour select bit 5 picks which 320x200 palette set is used
// RULE15 - colour select bit 4 enables alternate set in graphics, background in text
// RULE16 - colour select bits 3..0 give border, background, or 640 foreground colour
// RULE17 - mono status bit 7 reads zero during vertical retrace
// RULE18 - mono status bit 3 reports video enabled
// RULE19 - status bit 0 reads zero during display enable, one during blanking
// RULE20 - colour status bit 3 reads one during vertical retrace
// RULE21 - colour status bit 2 reads zero when light-pen switch closed
// RULE22 - colour status bit 1 reads one while light-pen latch set
// RULE23 - status reads have no side effects; reserved bits read zero
`timescale 1ns/1ps
`default_nettype none

module lacr_regs
    import lacr_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire lacr_io_req_t io_req_i,
    input  wire logic [7:0]   ext_video_select_reg_i,
    input  wire logic [7:0]   misc_output_i,
    input  wire lacr_raster_t raster_i,
    output logic [7:0]        io_rdata_o,
    output logic              io_rvalid_o,
    output lacr_mode_t        mode_o
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    lacr_state_t s_q;
    lacr_state_t s_d;
    logic        compat_en;
    logic [3:0]  mid_sel;
    logic        hit_mono_mode;
    logic        hit_wild_status;
    logic        hit_gpc;
    logic        hit_cmc;
    logic        hit_cps;
    logic        is_color;
    logic [7:0]  mono_stat;
    logic [7:0]  color_stat;
    logic        gfx_ok;

    assign compat_en = ext_video_select_reg_i[LACR_EXT_COMPAT_EN_BIT]; // RULE1
    assign is_color  = misc_output_i[LACR_MISC_COLOR_BIT];
    assign mid_sel   = is_color ? LACR_MID_COLOR : LACR_MID_MONO; // RULE3

    // mode control and status sit at wildcard ports; the low digit selects which
    assign hit_mono_mode   = compat_en && !is_color
                             && io_req_i.addr == LACR_MONO_MODE_CONTROL_ADDR; // RULE3
    assign hit_cmc         = compat_en && is_color
                             && io_req_i.addr == LACR_COLOR_MODE_CONTROL_ADDR; // RULE3
    assign hit_wild_status = compat_en && io_req_i.addr[9:8] == LACR_MONO_CRT_STATUS_ADDR[9:8]
                             && io_req_i.addr[7:4] == mid_sel
                             && io_req_i.addr[3:0] == LACR_MONO_CRT_STATUS_ADDR[3:0]; // RULE3
    assign hit_gpc         = compat_en && io_req_i.addr == LACR_GRAPHICS_PAGE_CONFIG_ADDR; // RULE7
    assign hit_cps         = compat_en && io_req_i.addr == LACR_COLOR_PALETTE_SELECT_ADDR;
    // the 400-line port sits outside this bank and gates on LACR_EXT_400L_EN_BIT // RULE2

    // ------------------------------------------------------------------
    // status images, reserved bits zero
    // ------------------------------------------------------------------
    always_comb begin
        mono_stat = 8'h00; // RULE23
        mono_stat[7] = ~raster_i.vretrace; // RULE17
        mono_stat[3] = s_q.mono_mode[LACR_MONO_VIDEO_BIT]; // RULE18
        mono_stat[0] = ~raster_i.disp_en; // RULE19
        color_stat = 8'h00; // RULE23
        color_stat[3] = raster_i.vretrace; // RULE20
        color_stat[2] = ~raster_i.pen_switch_closed; // RULE21
        color_stat[1] = raster_i.pen_latch; // RULE22
        color_stat[0] = ~raster_i.disp_en; // RULE19
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        if (io_req_i.wr) begin
            if (hit_mono_mode) begin
                s_d.mono_mode = io_req_i.wdata & LACR_MONO_MASK; // RULE5
            end
            if (hit_gpc) begin
                // override clear prevents setting the config bits
                if (s_q.mono_mode[LACR_MONO_GFXOVR_BIT]) begin
                    s_d.gpc = io_req_i.wdata & LACR_GPC_MASK; // RULE6
                end else begin
                    s_d.gpc = LACR_REG_RESET; // RULE6
                end
            end
            if (hit_cmc) begin
                s_d.cmc = io_req_i.wdata & LACR_CMC_MASK;
            end
            if (hit_cps) begin
                s_d.cps = io_req_i.wdata & LACR_CPS_MASK;
            end
        end
        // status read only returns data; nothing else moves
        if (io_req_i.rd && hit_wild_status) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = is_color ? color_stat : mono_stat; // RULE23
        end

        gfx_ok = compat_en && s_d.mono_mode[LACR_MONO_GFXOVR_BIT]
                 && s_d.gpc[LACR_GPC_GFX_BIT]; // RULE9
        s_d.mode.mono_graphics      = gfx_ok; // RULE9
        s_d.mode.mono_page_b800     = gfx_ok && s_d.mono_mode[LACR_MONO_PAGE_BIT]; // RULE4
        s_d.mode.mono_upper_page_en = compat_en && s_d.gpc[LACR_GPC_UPPER_BIT]; // RULE8
        s_d.mode.mono_blink_en      = s_d.mono_mode[LACR_MONO_BLINK_BIT]; // RULE5
        s_d.mode.mono_video_en      = s_d.mono_mode[LACR_MONO_VIDEO_BIT]; // RULE5
        s_d.mode.mono_hires         = s_d.mono_mode[LACR_MONO_HIRES_BIT]; // RULE5
        s_d.mode.color_blink_en     = s_d.cmc[LACR_CMC_BLINK_BIT]; // RULE10
        s_d.mode.color_bw640        = s_d.cmc[LACR_CMC_BW640_BIT]; // RULE11
        s_d.mode.color_video_en     = s_d.cmc[LACR_CMC_VIDEO_BIT]; // RULE12
        s_d.mode.color_gfx320       = s_d.cmc[LACR_CMC_GFX320_BIT]; // RULE13
        s_d.mode.color_text80       = s_d.cmc[LACR_CMC_TEXT80_BIT]; // RULE13
        s_d.mode.palette_out_bit5   = s_d.cps[LACR_CPS_PALSET_BIT]; // RULE14
        s_d.mode.palette_out_bit4   = s_d.cps[LACR_CPS_ALTSET_BIT]; // RULE15
        s_d.mode.palette_alt_set    = s_d.cps[LACR_CPS_ALTSET_BIT]
                                      && (s_d.cmc[LACR_CMC_GFX320_BIT]
                                          || s_d.cmc[LACR_CMC_BW640_BIT]); // RULE15
        s_d.mode.color_irgb         = s_d.cps[3:0]; // RULE16
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_rdata_o  = s_q.rdata;
    assign io_rvalid_o = s_q.rvalid;
    assign mode_o      = s_q.mode;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence seq_status_read;
        io_req_i.rd && hit_wild_status;
    endsequence

    AST_NO_ACCESS_OUTSIDE_COMPAT: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE1
        (io_req_i.wr && !compat_en) |=> s_q.cmc == $past(s_q.cmc) && s_q.cps == $past(s_q.cps))
        else $error("register changed outside compat mode");
    AST_NO_STATUS_OUTSIDE_COMPAT: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE1
        (io_req_i.rd && !compat_en) |=> !io_rvalid_o)
        else $error("status answered outside compat mode");
    AST_STATUS_ANSWER: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE3
        seq_status_read |=> io_rvalid_o ##1 !io_rvalid_o || $past(io_req_i.rd))
        else $error("status answer timing wrong");
    AST_MONO_VRETRACE: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE17
        (seq_status_read and !is_color) |=> io_rdata_o[7] == !$past(raster_i.vretrace))
        else $error("mono retrace bit wrong");
    AST_COLOR_STATUS: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE20
        (seq_status_read and is_color) |=> io_rdata_o[3] == $past(raster_i.vretrace)
            && io_rdata_o[1] == $past(raster_i.pen_latch) && io_rdata_o[7:4] == 4'h0)
        else $error("colour status bits wrong");
    AST_DISP_EN: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE19
        seq_status_read |=> io_rdata_o[0] == !$past(raster_i.disp_en))
        else $error("display enable bit wrong");
    AST_GFX_BLOCKED: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE6
        (io_req_i.wr && hit_gpc && !s_q.mono_mode[LACR_MONO_GFXOVR_BIT])
            |=> s_q.gpc == 8'h00 && !mode_o.mono_graphics)
        else $error("graphics config set while blocked");
    AST_PAGE_NEEDS_GFX: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE4
        mode_o.mono_page_b800 |-> mode_o.mono_graphics && s_q.mono_mode[LACR_MONO_PAGE_BIT])
        else $error("page select without graphics");
    AST_VIDEO_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE12
        (io_req_i.wr && hit_cmc && !io_req_i.wdata[LACR_CMC_VIDEO_BIT])
            |=> !mode_o.color_video_en)
        else $error("colour video stayed on");

    // ------------------------------------------------------------------
    // access sequences
    // ------------------------------------------------------------------
    sequence seq_mono_write;
        io_req_i.wr && hit_mono_mode;
    endsequence

    sequence seq_cmc_write;
        io_req_i.wr && hit_cmc;
    endsequence

    sequence seq_cps_write;
        io_req_i.wr && hit_cps;
    endsequence

    // config write while the override bit lets it through
    sequence seq_gpc_open_write;
        io_req_i.wr && hit_gpc && s_q.mono_mode[LACR_MONO_GFXOVR_BIT];
    endsequence

    sequence seq_mono_status_read;
        io_req_i.rd && hit_wild_status && !is_color;
    endsequence

    sequence seq_color_status_read;
        io_req_i.rd && hit_wild_status && is_color;
    endsequence

    // ------------------------------------------------------------------
    // mono mode and page config checks
    // ------------------------------------------------------------------
    AST_MONO_BLINK: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE5
        seq_mono_write
            |=> mode_o.mono_blink_en == $past(io_req_i.wdata[LACR_MONO_BLINK_BIT]))
        else $error("mono blink wrong");

    AST_MONO_VIDEO: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE5
        seq_mono_write
            |=> mode_o.mono_video_en == $past(io_req_i.wdata[LACR_MONO_VIDEO_BIT]))
        else $error("mono video wrong");

    AST_MONO_HIRES: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE5
        seq_mono_write
            |=> mode_o.mono_hires == $past(io_req_i.wdata[LACR_MONO_HIRES_BIT]))
        else $error("mono hires wrong");

    AST_MONO_HELD: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE1
        (io_req_i.wr && !compat_en)
            |=> s_q.mono_mode == $past(s_q.mono_mode) && s_q.gpc == $past(s_q.gpc))
        else $error("mono register changed outside compat mode");

    AST_MONO_PORT_IN_COLOR: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE3
        (io_req_i.wr && is_color && io_req_i.addr == LACR_MONO_MODE_CONTROL_ADDR)
            |=> s_q.mono_mode == $past(s_q.mono_mode))
        else $error("mono port answered in colour decode");

    AST_GPC_OPEN: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE6
        seq_gpc_open_write
            |=> s_q.gpc == ($past(io_req_i.wdata) & LACR_GPC_MASK))
        else $error("graphics config write lost");

    AST_GPC_TWO_BITS: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE7
        (s_q.gpc & ~LACR_GPC_MASK) == 8'h00)
        else $error("graphics config reserved bits set");

    AST_UPPER_PAGE: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE8
        mode_o.mono_upper_page_en
            |-> s_q.gpc[LACR_GPC_UPPER_BIT])
        else $error("upper page mapped while cleared");

    AST_TEXT_FORCED: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE9
        !s_q.gpc[LACR_GPC_GFX_BIT]
            |-> !mode_o.mono_graphics)
        else $error("graphics shown while config forces text");

    AST_GFX_NEEDS_OVR: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE6
        !s_q.mono_mode[LACR_MONO_GFXOVR_BIT]
            |-> !mode_o.mono_graphics)
        else $error("graphics shown without override");

    // colour mode and colour select checks
    AST_CMC_BLINK: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE10
        seq_cmc_write
            |=> mode_o.color_blink_en == $past(io_req_i.wdata[LACR_CMC_BLINK_BIT]))
        else $error("colour blink wrong");
    AST_CMC_BW640: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE11
        seq_cmc_write
            |=> mode_o.color_bw640 == $past(io_req_i.wdata[LACR_CMC_BW640_BIT]))
        else $error("colour 640 mode wrong");
    AST_CMC_VIDEO_ON: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE12
        seq_cmc_write
            |=> mode_o.color_video_en == $past(io_req_i.wdata[LACR_CMC_VIDEO_BIT]))
        else $error("colour video wrong");
    AST_CMC_GFX320: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE13
        seq_cmc_write
            |=> mode_o.color_gfx320 == $past(io_req_i.wdata[LACR_CMC_GFX320_BIT]))
        else $error("colour 320 mode wrong");
    AST_CMC_TEXT80: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE13
        seq_cmc_write
            |=> mode_o.color_text80 == $past(io_req_i.wdata[LACR_CMC_TEXT80_BIT]))
        else $error("colour 80 column wrong");
    AST_CPS_PALSET: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE14
        seq_cps_write
            |=> mode_o.palette_out_bit5 == $past(io_req_i.wdata[LACR_CPS_PALSET_BIT]))
        else $error("palette set wrong");
    AST_CPS_ALTSET: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE15
        seq_cps_write
            |=> mode_o.palette_out_bit4 == $past(io_req_i.wdata[LACR_CPS_ALTSET_BIT]))
        else $error("alternate set wrong");
    AST_CPS_IRGB: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE16
        seq_cps_write
            |=> mode_o.color_irgb == $past(io_req_i.wdata[3:0]))
        else $error("border colour wrong");

    // status images and read side effects
    AST_MONO_VIDEO_STAT: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE18
        seq_mono_status_read
            |=> io_rdata_o[3] == $past(s_q.mono_mode[LACR_MONO_VIDEO_BIT]))
        else $error("mono video status wrong");
    AST_MONO_RESERVED: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE23
        seq_mono_status_read
            |=> (io_rdata_o & 8'h76) == 8'h00)
        else $error("mono reserved status bits set");
    AST_PEN_SWITCH: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE21
        seq_color_status_read
            |=> io_rdata_o[2] == !$past(raster_i.pen_switch_closed))
        else $error("pen switch bit wrong");
    AST_READ_NO_SIDE: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE23
        (io_req_i.rd && !io_req_i.wr)
            |=> s_q.mono_mode == $past(s_q.mono_mode) && s_q.cmc == $past(s_q.cmc))
        else $error("read changed a register");
    AST_RDATA_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE23
        !(io_req_i.rd && hit_wild_status)
            |=> $stable(io_rdata_o))
        else $error("read data moved without a read");
    AST_RVALID_PULSE: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE23
        !(io_req_i.rd && hit_wild_status)
            |=> !io_rvalid_o)
        else $error("read valid without a status read");
    AST_NO_READ_WO: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE7
        (io_req_i.rd && io_req_i.addr == LACR_GRAPHICS_PAGE_CONFIG_ADDR)
            |=> !io_rvalid_o)
        else $error("write-only port answered a read");
    AST_WRONG_MID: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE3
        (io_req_i.rd && is_color && io_req_i.addr == LACR_MONO_CRT_STATUS_ADDR)
            |=> !io_rvalid_o)
        else $error("mono status answered in colour decode");

endmodule

`default_nettype wire

// ### dv/lacr_host_model.sv
// lacr_host_model: host software model issuing single i/o port cycles.
// assumes the bench calls access(); strobes last one clock, lines scrambled when idle.
`timescale 1ns/1ps
`default_nettype none

module lacr_host_model
    import lacr_pkg::*;
(
    input  wire logic         clk_i,
    output var lacr_io_req_t  io_req_o
);
    initial begin
        io_req_o = '0;
    end

    // released address and data show the inverse, not the last value
    task automatic access(input logic rd, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_i);
        io_req_o <= '{rd: rd, wr: !rd, addr: a, wdata: d};
        @(posedge clk_i);
        io_req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule
`default_nettype wire

// ### dv/legacy_adapter_compat_regs_tb.sv
// legacy_adapter_compat_regs_tb: self-checking bench for lacr_regs.
// assumes lacr_pkg and lacr_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module legacy_adapter_compat_regs_tb;
    import lacr_pkg::*;
    logic         clk_i;
    logic         resetn_i;
    lacr_io_req_t io_req;
    logic [7:0]   ext_sel;
    logic [7:0]   misc;
    lacr_raster_t raster;
    logic [7:0]   io_rdata;
    logic         io_rvalid;
    lacr_mode_t   mode;
    logic [7:0]   exp_q[$];
    int           n_fail;
    int           n_checks;
    int           cycles;
    int           seed;
    logic [7:0]   v;
    logic [7:0]   c;
    lacr_raster_t r;

    lacr_host_model i_lacr_host_model (.clk_i(clk_i), .io_req_o(io_req));

    lacr_regs i_lacr_regs (
        .clk_i                  (clk_i),
        .resetn_i               (resetn_i),
        .io_req_i               (io_req),
        .ext_video_select_reg_i (ext_sel),
        .misc_output_i          (misc),
        .raster_i               (raster),
        .io_rdata_o             (io_rdata),
        .io_rvalid_o            (io_rvalid),
        .mode_o                 (mode)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            close_out();
        end
    end

    // read results are matched against the oldest note
    always @(negedge clk_i) begin
        if (io_rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                check("unexpected read", 32'h1, 32'h0);
            else
                check("status read", io_rdata, exp_q.pop_front());
        end
    end

    // ------------------------------------------------------------------
    // access helpers
    // ------------------------------------------------------------------
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        i_lacr_host_model.access(1'b0, a, d);
        @(negedge clk_i);
    endtask

    task automatic rd(input logic [9:0] a, input logic hit, input logic [7:0] e);
        if (hit)
            exp_q.push_back(e);
        i_lacr_host_model.access(1'b1, a, 8'h00);
        repeat (2) @(posedge clk_i);
    endtask

    function automatic logic [7:0] st_exp(input logic col, input lacr_raster_t x, input logic mv);
        if (col)
            return {4'h0, x.vretrace, !x.pen_switch_closed, x.pen_latch, !x.disp_en};
        return {!x.vretrace, 3'b000, mv, 2'b00, !x.disp_en};
    endfunction

    task automatic status_reads(input logic col, input logic mv);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            r = lacr_raster_t'($random(seed));
            raster <= r;
            rd(col ? LACR_COLOR_CRT_STATUS_ADDR : LACR_MONO_CRT_STATUS_ADDR, 1'b1,
               st_exp(col, r, mv));
        end
    endtask

    task automatic mono_chk(input logic [5:0] e);
        check("mono mode", {mode.mono_page_b800, mode.mono_blink_en, mode.mono_video_en,
              mode.mono_hires, mode.mono_graphics, mode.mono_upper_page_en}, e);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 74331;
        resetn_i = 1'b0;
        ext_sel = 8'h00;
        misc = 8'h01;
        raster = '0;
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(negedge clk_i);
        check("mode after reset", mode, 32'h0);
        wr(LACR_COLOR_MODE_CONTROL_ADDR, 8'h08);
        check("refused write", mode.color_video_en, 32'h0);
        rd(LACR_COLOR_CRT_STATUS_ADDR, 1'b0, 8'h00);
        @(posedge clk_i);
        ext_sel <= 8'h40;
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed)) & LACR_CMC_MASK;
            wr(LACR_COLOR_MODE_CONTROL_ADDR, v);
            check("colour mode", {mode.color_blink_en, mode.color_bw640, mode.color_video_en,
                  mode.color_gfx320, mode.color_text80}, {v[5:3], v[1:0]});
            c = 8'($random(seed));
            wr(LACR_COLOR_PALETTE_SELECT_ADDR, c);
            check("border colour", mode.color_irgb, c[3:0]);
            check("alt set", mode.palette_alt_set, c[4] & (v[1] | v[4]));
            check("palette bits", {mode.palette_out_bit5, mode.palette_out_bit4}, c[5:4]);
        end
        status_reads(1'b1, 1'b0);
        rd(LACR_MONO_CRT_STATUS_ADDR, 1'b0, 8'h00);
        rd(LACR_COLOR_MODE_CONTROL_ADDR, 1'b0, 8'h00);
        @(posedge clk_i);
        misc <= 8'h00;
        wr(LACR_COLOR_MODE_CONTROL_ADDR, ~v);
        check("colour write in mono", mode.color_video_en, v[3]);
        wr(LACR_MONO_MODE_CONTROL_ADDR, 8'h2b);
        mono_chk(6'b011100);
        status_reads(1'b0, 1'b1);
        wr(LACR_GRAPHICS_PAGE_CONFIG_ADDR, 8'h03);
        mono_chk(6'b011111);
        wr(LACR_MONO_MODE_CONTROL_ADDR, 8'hab);
        mono_chk(6'b111111);
        wr(LACR_GRAPHICS_PAGE_CONFIG_ADDR, 8'h01);
        mono_chk(6'b111110);
        wr(LACR_MONO_MODE_CONTROL_ADDR, 8'h81);
        mono_chk(6'b000100);
        wr(LACR_GRAPHICS_PAGE_CONFIG_ADDR, 8'h03);
        wr(LACR_MONO_MODE_CONTROL_ADDR, 8'h83);
        mono_chk(6'b000100);
        status_reads(1'b0, 1'b0);
        repeat (4) @(posedge clk_i);
        close_out();
    end
endmodule
`default_nettype wire

// ### pkg/lacr_pkg.sv
// lacr_pkg: constants and carrier types for the legacy adapter compatibility registers.
// assumes an 8-bit host i/o port bus with 10-bit port addresses.
package lacr_pkg;

    // ------------------------------------------------------------------
    // port addresses
    // ------------------------------------------------------------------
    localparam logic [9:0] LACR_MONO_MODE_CONTROL_ADDR    = 10'h3b8;
    localparam logic [9:0] LACR_MONO_CRT_STATUS_ADDR      = 10'h3ba;
    localparam logic [9:0] LACR_GRAPHICS_PAGE_CONFIG_ADDR = 10'h3bf;
    localparam logic [9:0] LACR_COLOR_MODE_CONTROL_ADDR   = 10'h3d8;
    localparam logic [9:0] LACR_COLOR_PALETTE_SELECT_ADDR = 10'h3d9;
    localparam logic [9:0] LACR_COLOR_CRT_STATUS_ADDR     = 10'h3da;
    // middle digit of a wildcard port: b for mono, d for colour
    localparam logic [3:0] LACR_MID_MONO                  = 4'hb;
    localparam logic [3:0] LACR_MID_COLOR                 = 4'hd;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int LACR_EXT_COMPAT_EN_BIT = 6;
    localparam int LACR_EXT_400L_EN_BIT   = 7;
    localparam int LACR_MISC_COLOR_BIT    = 0;
    localparam int LACR_MONO_PAGE_BIT     = 7;
    localparam int LACR_MONO_BLINK_BIT    = 5;
    localparam int LACR_MONO_VIDEO_BIT    = 3;
    localparam int LACR_MONO_GFXOVR_BIT   = 1;
    localparam int LACR_MONO_HIRES_BIT    = 0;
    localparam int LACR_GPC_UPPER_BIT     = 1;
    localparam int LACR_GPC_GFX_BIT       = 0;
    localparam int LACR_CMC_BLINK_BIT     = 5;
    localparam int LACR_CMC_BW640_BIT     = 4;
    localparam int LACR_CMC_VIDEO_BIT     = 3;
    localparam int LACR_CMC_GFX320_BIT    = 1;
    localparam int LACR_CMC_TEXT80_BIT    = 0;
    localparam int LACR_CPS_PALSET_BIT    = 5;
    localparam int LACR_CPS_ALTSET_BIT    = 4;

    // ------------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------------
    localparam logic [7:0] LACR_REG_RESET = 8'h00;
    localparam logic [7:0] LACR_MONO_MASK = 8'hab;
    localparam logic [7:0] LACR_GPC_MASK  = 8'h03;
    localparam logic [7:0] LACR_CMC_MASK  = 8'h3f;
    localparam logic [7:0] LACR_CPS_MASK  = 8'h3f;

    // host i/o request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } lacr_io_req_t;

    // raster state from the crt timing logic
    typedef struct packed {
        logic vretrace;
        logic disp_en;
        logic pen_switch_closed;
        logic pen_latch;
    } lacr_raster_t;

    // decoded mode outputs
    typedef struct packed {
        logic       mono_page_b800;
        logic       mono_blink_en;
        logic       mono_video_en;
        logic       mono_hires;
        logic       mono_graphics;
        logic       mono_upper_page_en;
        logic       color_blink_en;
        logic       color_bw640;
        logic       color_video_en;
        logic       color_gfx320;
        logic       color_text80;
        logic       palette_alt_set;
        logic       palette_out_bit5;
        logic       palette_out_bit4;
        logic [3:0] color_irgb;
    } lacr_mode_t;

    // whole block state
    typedef struct packed {
        logic [7:0] mono_mode;
        logic [7:0] gpc;
        logic [7:0] cmc;
        logic [7:0] cps;
        logic [7:0] rdata;
        logic       rvalid;
        lacr_mode_t mode;
    } lacr_state_t;

endpackage
